// [src/occs_params.svh]
// Register map, field positions, reset values and timing counts of the clock control block
`ifndef OCCS_PARAMS_SVH
`define OCCS_PARAMS_SVH
`define OCCS_ADDR_W 5
`define OCCS_OFF_CONTROL 5'h00
`define OCCS_OFF_TUNING 5'h04
`define OCCS_OFF_IRQ_STAT 5'h08
`define OCCS_OFF_IRQ_MASK 5'h0C
`define OCCS_OFF_STATE 5'h10
`define OCCS_CTL_IDLE_BIT 7
`define OCCS_CTL_FREQ_HI 6
`define OCCS_CTL_FREQ_LO 4
`define OCCS_CTL_STARTUP_BIT 3
`define OCCS_CTL_STABLE_BIT 2
`define OCCS_CTL_SRC_HI 1
`define OCCS_CTL_SRC_LO 0
`define OCCS_TUN_LFSRC_BIT 7
`define OCCS_TUN_PLL_BIT 6
`define OCCS_TUN_TRIM_HI 5
`define OCCS_TUN_TRIM_LO 0
`define OCCS_FREQ_RESET 3'h6
`define OCCS_FREQ_LOWEST 3'h0
`define OCCS_TUNING_RESET 8'h00
`define OCCS_IRQ_N 4
`define OCCS_IRQ_SWITCH_DONE 0
`define OCCS_IRQ_STARTUP_DONE 1
`define OCCS_IRQ_RC_STABLE 2
`define OCCS_IRQ_POWER_DOWN 3
`define OCCS_MCLK_HZ 25000000
`define OCCS_STARTUP_CYCLES 11'd1024
`define OCCS_OLD_TICKS 2'd2
`define OCCS_NEW_TICKS 2'd3
`define OCCS_CLKOUT_DIV 2'd2
`endif

// [src/occs_pkg.sv]
// Types shared by the clock control block
package occs_pkg;
  typedef enum logic [2:0] {
    OCCS_MODE_EXT_PLL = 3'b000,
    OCCS_MODE_EXT = 3'b001,
    OCCS_MODE_XTAL_PLL = 3'b010,
    OCCS_MODE_XTAL = 3'b011,
    OCCS_MODE_INT_PLL_CLKOUT = 3'b100,
    OCCS_MODE_INT_CLKOUT = 3'b101,
    OCCS_MODE_INT_PLL_IO = 3'b110,
    OCCS_MODE_INT_IO = 3'b111
  } occs_mode_e;
  typedef enum logic [1:0] {
    OCCS_SRC_DEFAULT = 2'b00,
    OCCS_SRC_SECONDARY = 2'b01,
    OCCS_SRC_PRIMARY = 2'b10,
    OCCS_SRC_INTERNAL = 2'b11
  } occs_src_e;
  typedef enum logic [1:0] {
    OCCS_SW_IDLE = 2'b00,
    OCCS_SW_OLD = 2'b01,
    OCCS_SW_NEW = 2'b10
  } occs_sw_state_e;
  typedef struct packed {
    logic read;
    logic write;
    logic [4:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } occs_avm_req_s;
  typedef struct packed {
    logic drive;
    logic oe;
  } occs_pin_s;
endpackage

// [src/occs_switch.sv]
// Glitch-free system clock source switch sequencer
`timescale 1ns/10ps
`include "occs_params.svh"
module occs_switch (
  input wire logic mclk_in, // System clock
  input wire logic rst_n_in, // Async reset, active low
  input wire logic ce_in, // Clock enable
  input wire logic start_in, // Pulse: begin a switch
  input wire occs_pkg::occs_src_e target_in, // Resolved new source
  input wire logic [3:0] tick_in, // One tick per source, indexed by code
  input wire logic [3:0] stable_in, // Source stable, indexed by code
  output occs_pkg::occs_src_e active_out, // Source now clocking the core
  output logic busy_out, // Clock paused while high
  output logic done_out // Pulse: switch complete
);
  import occs_pkg::*;
  occs_sw_state_e state;
  occs_src_e target;
  logic [1:0] tick_cnt;

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state <= OCCS_SW_IDLE;
      target <= OCCS_SRC_PRIMARY;
      active_out <= OCCS_SRC_PRIMARY;
      tick_cnt <= 2'h0;
      done_out <= 1'b0;
    end
    else if (ce_in)
    begin
      done_out <= 1'b0;
      // A new request restarts the sequence toward the latest target
      if (start_in)
      begin
        state <= OCCS_SW_OLD;
        target <= target_in;
        tick_cnt <= 2'h0;
      end
      else
      begin
        case (state)
          OCCS_SW_OLD:
          begin
            if (tick_in[active_out])
            begin
              if (tick_cnt == `OCCS_OLD_TICKS - 2'd1)
              begin
                state <= OCCS_SW_NEW;
                tick_cnt <= 2'h0;
              end
              else
                tick_cnt <= tick_cnt + 2'd1;
            end
          end
          OCCS_SW_NEW:
          begin
            // New ticks only count once the new source is stable
            if (tick_in[target] && stable_in[target])
            begin
              if (tick_cnt == `OCCS_NEW_TICKS - 2'd1)
              begin
                state <= OCCS_SW_IDLE;
                active_out <= target;
                done_out <= 1'b1;
                tick_cnt <= 2'h0;
              end
              else
                tick_cnt <= tick_cnt + 2'd1;
            end
          end
          default:
            state <= OCCS_SW_IDLE;
        endcase
      end
    end
  end

  assign busy_out = (state != OCCS_SW_IDLE);
endmodule // occs_switch

// [src/occs_top.sv]
// Oscillator mode, clock select and tuning control block with Avalon-MM registers
`timescale 1ns/10ps
`include "occs_params.svh"
// Function
// - Eight oscillator modes from three-bit configuration
// - External clock mode drives Fosc/4 out
// - First internal modes: clock out pin6, pin7 I/O
// - Second internal modes: pins 6, 7 I/O
// - Idle bit picks idle or sleep
// - Fast RC frequency code, reset 110
// - Frequency change applies at once on internal
// - Lowest code: divided fast RC or slow RC
// - Start-up done after timer, reset follows config
// - Fast RC stable flag, resets zero
// - Two-bit source select decoding
// - Source select change starts switch
// - PLL enable bit, resets zero
// - Six-bit signed trim, resets zero
// - Reset clears source select
// - Glitch-free switch: 2 old, 3 new
module occs_top (
  input wire logic mclk_in, // System clock, 25 MHz
  input wire logic rst_n_in, // Async reset, active low
  input wire logic ce_in, // Clock enable, freezes state when low
  input wire occs_pkg::occs_avm_req_s avm_req_in, // Avalon-MM request
  output logic [31:0] avm_readdata_out, // Avalon-MM read data
  output logic avm_waitrequest_out, // Avalon-MM waitrequest
  output logic irq_out, // Level interrupt
  input wire occs_pkg::occs_mode_e osc_mode_cfg_in, // Nonvolatile mode field
  input wire logic two_speed_startup_cfg_in, // Two-speed start-up config
  input wire logic primary_osc_in, // Primary clock pin level
  input wire logic primary_running_in, // Primary oscillator oscillating
  input wire logic secondary_running_in, // Secondary oscillator stable
  input wire logic fast_rc_ready_in, // Fast RC frequency settled
  input wire logic [3:0] src_tick_in, // Per-source tick strobes
  input wire logic sleep_exec_in, // Pulse: sleep instruction executed
  input wire occs_pkg::occs_pin_s gpio6_in, // Port logic drive for pin 6
  input wire occs_pkg::occs_pin_s gpio7_in, // Port logic drive for pin 7
  input wire logic port_a_pin6_in, // Pin 6 level
  input wire logic port_a_pin7_in, // Pin 7 level
  output logic port_a_pin6_out, // Pin 6 drive value
  output logic port_a_pin6_oe_out, // Pin 6 output enable
  output logic port_a_pin7_out, // Pin 7 drive value
  output logic port_a_pin7_oe_out, // Pin 7 output enable
  output logic primary_osc_out, // Primary output pin drive value
  output logic primary_osc_oe_out, // Primary output pin enable
  output logic [1:0] gpio_level_out, // Registered pin 7/6 levels
  output occs_pkg::occs_src_e active_src_out, // Source clocking the core
  output logic clock_pause_out, // Core clock held during switch
  output logic [2:0] fast_rc_freq_sel_out, // Fast RC postscaler code
  output logic fast_rc_div256_out, // Low clock from fast RC / 256
  output logic freq_apply_out, // Pulse: new fast RC rate applied
  output logic [5:0] fast_rc_trim_out, // Fast RC trim value
  output logic pll_on_out, // PLL running
  output logic idle_enter_out, // Pulse: enter idle
  output logic sleep_enter_out // Pulse: enter sleep
);
  import occs_pkg::*;

  function automatic logic is_internal(input occs_mode_e m);
    is_internal = m[2];
  endfunction

  function automatic occs_src_e resolve_src(input logic [1:0] sel, input occs_mode_e m);
    if (sel == OCCS_SRC_DEFAULT)
      resolve_src = is_internal(m) ? OCCS_SRC_INTERNAL : OCCS_SRC_PRIMARY;
    else
      resolve_src = occs_src_e'(sel);
  endfunction

  function automatic logic is_pll_mode(input occs_mode_e m);
    is_pll_mode = (m == OCCS_MODE_XTAL_PLL) || (m == OCCS_MODE_INT_PLL_CLKOUT) ||
                  (m == OCCS_MODE_INT_PLL_IO);
  endfunction

  logic idle_on_sleep_sel;
  logic [2:0] fast_rc_freq_sel;
  logic primary_startup_done;
  logic fast_rc_stable;
  logic [1:0] sysclk_source_sel;
  logic low_freq_source_sel;
  logic pll_enable_bit;
  logic [5:0] fast_rc_trim;
  logic [`OCCS_IRQ_N-1:0] irq_stat;
  logic [`OCCS_IRQ_N-1:0] irq_mask;
  logic [`OCCS_IRQ_N-1:0] irq_event;
  logic bus_ack;
  logic bus_req;
  logic wr_fire;
  logic wr_lane0;
  logic [7:0] wdata;
  logic [31:0] next_readdata;
  logic init_pending;
  logic [10:0] startup_cnt;
  logic startup_done_q;
  logic stable_q;
  logic src_start;
  occs_src_e target_src;
  logic [3:0] src_stable;
  logic switch_done;
  logic [1:0] clkout_div;
  logic clkout;
  logic [7:0] osc_control_reg;
  logic [7:0] osc_tuning_reg;

  // One wait state: request seen, then completed on the next edge
  assign bus_req = avm_req_in.read | avm_req_in.write;
  assign avm_waitrequest_out = bus_req & ~bus_ack;
  assign wr_fire = ce_in & avm_req_in.write & bus_ack;
  assign wr_lane0 = wr_fire & avm_req_in.byteenable[0];
  assign wdata = avm_req_in.writedata[7:0];

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      bus_ack <= 1'b0;
    else if (ce_in)
      bus_ack <= bus_req & ~bus_ack;
  end

  assign osc_control_reg = {idle_on_sleep_sel, fast_rc_freq_sel, primary_startup_done,
                            fast_rc_stable, sysclk_source_sel};
  assign osc_tuning_reg = {low_freq_source_sel, pll_enable_bit, fast_rc_trim};

  always_comb
  begin
    next_readdata = 32'h0000_0000;
    case (avm_req_in.address)
      `OCCS_OFF_CONTROL: next_readdata[7:0] = osc_control_reg;
      `OCCS_OFF_TUNING: next_readdata[7:0] = osc_tuning_reg;
      `OCCS_OFF_IRQ_STAT: next_readdata[`OCCS_IRQ_N-1:0] = irq_stat;
      `OCCS_OFF_IRQ_MASK: next_readdata[`OCCS_IRQ_N-1:0] = irq_mask;
      `OCCS_OFF_STATE: next_readdata[7:0] = {1'b0, osc_mode_cfg_in, 1'b0,
                                             clock_pause_out, active_src_out};
      default: next_readdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      avm_readdata_out <= 32'h0000_0000;
    else if (ce_in && avm_req_in.read && !bus_ack)
      avm_readdata_out <= next_readdata;
  end

  // Control register, writable fields
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      idle_on_sleep_sel <= 1'b0;
      fast_rc_freq_sel <= `OCCS_FREQ_RESET;
      sysclk_source_sel <= 2'b00;
    end
    else if (wr_lane0 && avm_req_in.address == `OCCS_OFF_CONTROL)
    begin
      idle_on_sleep_sel <= wdata[`OCCS_CTL_IDLE_BIT];
      fast_rc_freq_sel <= wdata[`OCCS_CTL_FREQ_HI:`OCCS_CTL_FREQ_LO];
      sysclk_source_sel <= wdata[`OCCS_CTL_SRC_HI:`OCCS_CTL_SRC_LO];
    end
  end

  // Tuning register
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      low_freq_source_sel <= 1'(`OCCS_TUNING_RESET >> `OCCS_TUN_LFSRC_BIT);
      pll_enable_bit <= 1'b0;
      fast_rc_trim <= 6'h00;
    end
    else if (wr_lane0 && avm_req_in.address == `OCCS_OFF_TUNING)
    begin
      low_freq_source_sel <= wdata[`OCCS_TUN_LFSRC_BIT];
      pll_enable_bit <= wdata[`OCCS_TUN_PLL_BIT];
      fast_rc_trim <= wdata[`OCCS_TUN_TRIM_HI:`OCCS_TUN_TRIM_LO];
    end
  end

  // Start-up timer restarts whenever the primary oscillator stops
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      startup_cnt <= 11'h000;
      startup_done_q <= 1'b0;
    end
    else if (ce_in)
    begin
      if (!primary_running_in)
      begin
        startup_cnt <= 11'h000;
        startup_done_q <= 1'b0;
      end
      else if (startup_cnt == `OCCS_STARTUP_CYCLES - 11'd1)
        startup_done_q <= 1'b1;
      else
        startup_cnt <= startup_cnt + 11'd1;
    end
  end

  // Config strap is caught on the first clocked cycle after release
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      init_pending <= 1'b1;
    else if (ce_in)
      init_pending <= 1'b0;
  end

  // Status bits follow hardware only; bus writes never reach them
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      primary_startup_done <= 1'b0;
      fast_rc_stable <= 1'b0;
      stable_q <= 1'b0;
    end
    else if (ce_in)
    begin
      if (init_pending)
        primary_startup_done <= two_speed_startup_cfg_in;
      else
        primary_startup_done <= startup_done_q;
      fast_rc_stable <= fast_rc_ready_in;
      stable_q <= fast_rc_stable;
    end
  end

  // Sleep instruction outcome
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      idle_enter_out <= 1'b0;
      sleep_enter_out <= 1'b0;
    end
    else if (ce_in)
    begin
      idle_enter_out <= sleep_exec_in & idle_on_sleep_sel;
      sleep_enter_out <= sleep_exec_in & ~idle_on_sleep_sel;
    end
  end

  // Source switch request on any change of the select field
  assign target_src = resolve_src(wr_lane0 && avm_req_in.address == `OCCS_OFF_CONTROL ?
                                  wdata[`OCCS_CTL_SRC_HI:`OCCS_CTL_SRC_LO] :
                                  sysclk_source_sel, osc_mode_cfg_in);
  assign src_start = init_pending |
                     (wr_lane0 && avm_req_in.address == `OCCS_OFF_CONTROL &&
                      wdata[`OCCS_CTL_SRC_HI:`OCCS_CTL_SRC_LO] != sysclk_source_sel);

  // Slow RC is always running, so the lowest code with the slow RC selected never waits on the fast RC
  assign src_stable[OCCS_SRC_DEFAULT] = 1'b0;
  assign src_stable[OCCS_SRC_SECONDARY] = secondary_running_in;
  assign src_stable[OCCS_SRC_PRIMARY] = startup_done_q;
  assign src_stable[OCCS_SRC_INTERNAL] = fast_rc_stable |
    (fast_rc_freq_sel == `OCCS_FREQ_LOWEST && !low_freq_source_sel);

  occs_switch u_switch (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .start_in(src_start),
    .target_in(target_src),
    .tick_in(src_tick_in),
    .stable_in(src_stable),
    .active_out(active_src_out),
    .busy_out(clock_pause_out),
    .done_out(switch_done)
  );

  // Fast RC settings take effect with no handshake
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      fast_rc_freq_sel_out <= `OCCS_FREQ_RESET;
      fast_rc_div256_out <= 1'b0;
      freq_apply_out <= 1'b0;
      fast_rc_trim_out <= 6'h00;
      pll_on_out <= 1'b0;
    end
    else if (ce_in)
    begin
      fast_rc_freq_sel_out <= fast_rc_freq_sel;
      fast_rc_div256_out <= (fast_rc_freq_sel == `OCCS_FREQ_LOWEST) &
                            low_freq_source_sel;
      freq_apply_out <= (fast_rc_freq_sel != fast_rc_freq_sel_out) &&
                        (active_src_out == OCCS_SRC_INTERNAL);
      fast_rc_trim_out <= fast_rc_trim;
      pll_on_out <= (osc_mode_cfg_in == OCCS_MODE_EXT_PLL) |
                    (pll_enable_bit & is_pll_mode(osc_mode_cfg_in));
    end
  end

  // Instruction-rate clock: core clock divided by four
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      clkout_div <= 2'h0;
      clkout <= 1'b0;
    end
    else if (ce_in && !clock_pause_out)
    begin
      if (clkout_div == `OCCS_CLKOUT_DIV - 2'd1)
      begin
        clkout_div <= 2'h0;
        clkout <= ~clkout;
      end
      else
        clkout_div <= clkout_div + 2'd1;
    end
  end

  // Pin functions per oscillator mode
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      primary_osc_out <= 1'b0;
      primary_osc_oe_out <= 1'b0;
      port_a_pin6_out <= 1'b0;
      port_a_pin6_oe_out <= 1'b0;
      port_a_pin7_out <= 1'b0;
      port_a_pin7_oe_out <= 1'b0;
      gpio_level_out <= 2'b00;
    end
    else if (ce_in)
    begin
      primary_osc_out <= 1'b0;
      primary_osc_oe_out <= 1'b0;
      port_a_pin6_out <= 1'b0;
      port_a_pin6_oe_out <= 1'b0;
      port_a_pin7_out <= gpio7_in.drive;
      port_a_pin7_oe_out <= gpio7_in.oe;
      gpio_level_out <= {port_a_pin7_in, port_a_pin6_in};
      case (osc_mode_cfg_in)
        OCCS_MODE_EXT:
        begin
          primary_osc_out <= clkout;
          primary_osc_oe_out <= 1'b1;
        end
        OCCS_MODE_EXT_PLL:
        begin
          port_a_pin6_out <= clkout;
          port_a_pin6_oe_out <= 1'b1;
        end
        OCCS_MODE_INT_PLL_CLKOUT, OCCS_MODE_INT_CLKOUT:
        begin
          port_a_pin6_out <= clkout;
          port_a_pin6_oe_out <= 1'b1;
        end
        OCCS_MODE_INT_PLL_IO, OCCS_MODE_INT_IO:
        begin
          port_a_pin6_out <= gpio6_in.drive;
          port_a_pin6_oe_out <= gpio6_in.oe;
        end
        default:
        begin
          // Crystal modes: pin 6 belongs to the analogue amplifier, pin 7 stays port I/O
          port_a_pin6_oe_out <= 1'b0;
        end
      endcase
    end
  end

  // Interrupt events
  assign irq_event[`OCCS_IRQ_SWITCH_DONE] = switch_done;
  assign irq_event[`OCCS_IRQ_STARTUP_DONE] = startup_done_q & ~primary_startup_done &
                                             ~init_pending;
  assign irq_event[`OCCS_IRQ_RC_STABLE] = fast_rc_stable & ~stable_q;
  assign irq_event[`OCCS_IRQ_POWER_DOWN] = idle_enter_out | sleep_enter_out;

  genvar gi;
  generate
    for (gi = 0; gi < `OCCS_IRQ_N; gi = gi + 1)
    begin : g_irq
      // Set wins over a simultaneous write-one clear
      always_ff @(posedge mclk_in or negedge rst_n_in)
      begin
        if (!rst_n_in)
          irq_stat[gi] <= 1'b0;
        else if (ce_in)
        begin
          if (irq_event[gi])
            irq_stat[gi] <= 1'b1;
          else if (wr_lane0 && avm_req_in.address == `OCCS_OFF_IRQ_STAT && wdata[gi])
            irq_stat[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      irq_mask <= '0;
    else if (wr_lane0 && avm_req_in.address == `OCCS_OFF_IRQ_MASK)
      irq_mask <= wdata[`OCCS_IRQ_N-1:0];
  end

  assign irq_out = |(irq_stat & irq_mask);
endmodule // occs_top

// [tb/occs_assertions.sv]
// Port-level concurrent checks for the clock control block
`timescale 1ns/10ps
module occs_assertions (
  input wire logic mclk_in, // System clock
  input wire logic rst_n_in, // Reset, active low
  input wire occs_pkg::occs_avm_req_s avm_req_in, // Bus request
  input wire logic avm_waitrequest_out, // Bus wait
  input wire occs_pkg::occs_mode_e osc_mode_cfg_in, // Mode strap
  input wire occs_pkg::occs_pin_s gpio6_in, // Port drive pin 6
  input wire occs_pkg::occs_pin_s gpio7_in, // Port drive pin 7
  input wire logic port_a_pin6_oe_out, // Pin 6 enable
  input wire logic port_a_pin7_oe_out, // Pin 7 enable
  input wire logic primary_osc_oe_out, // Primary out enable
  input wire occs_pkg::occs_src_e active_src_out, // Active source
  input wire logic clock_pause_out, // Switch pause
  input wire logic freq_apply_out, // Rate applied
  input wire logic pll_on_out, // PLL running
  input wire logic sleep_exec_in, // Sleep pulse
  input wire logic idle_enter_out, // Idle pulse
  input wire logic sleep_enter_out // Sleep pulse out
);
  import occs_pkg::*;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  property p_wait;
    (avm_req_in.read || avm_req_in.write) && avm_waitrequest_out |=> !avm_waitrequest_out;
  endproperty
  property p_sleep;
    sleep_exec_in |=> idle_enter_out != sleep_enter_out;
  endproperty
  property p_pause;
    $rose(clock_pause_out) |-> clock_pause_out [*4];
  endproperty
  // Source may only move on the edge that ends a pause
  property p_src_hold;
    !clock_pause_out && $past(!clock_pause_out) |-> $stable(active_src_out);
  endproperty
  property p_apply;
    freq_apply_out |-> active_src_out == OCCS_SRC_INTERNAL;
  endproperty
  property p_io;
    osc_mode_cfg_in[2:1] == 2'b11 |=> port_a_pin6_oe_out == $past(gpio6_in.oe);
  endproperty
  property p_clkout;
    osc_mode_cfg_in[2:1] == 2'b10 |=> port_a_pin6_oe_out;
  endproperty
  property p_pin7;
    1'b1 |=> port_a_pin7_oe_out == $past(gpio7_in.oe);
  endproperty
  property p_ext;
    osc_mode_cfg_in == OCCS_MODE_EXT |=> primary_osc_oe_out;
  endproperty
  property p_pll;
    osc_mode_cfg_in == OCCS_MODE_EXT_PLL |=> pll_on_out;
  endproperty
  a_wait: assert property (p_wait) else $error("waitrequest held too long");
  a_sleep: assert property (p_sleep) else $error("sleep entry wrong");
  a_pause: assert property (p_pause) else $error("switch pause too short");
  a_src_hold: assert property (p_src_hold) else $error("source moved unpaused");
  a_apply: assert property (p_apply) else $error("rate applied off internal");
  a_io: assert property (p_io) else $error("pin 6 not port I/O");
  a_clkout: assert property (p_clkout) else $error("pin 6 not clock out");
  a_pin7: assert property (p_pin7) else $error("pin 7 not port I/O");
  a_ext: assert property (p_ext) else $error("primary out not driven");
  a_pll: assert property (p_pll) else $error("PLL off in ext PLL mode");
  c_pause: cover property ($rose(clock_pause_out));
  c_idle: cover property (sleep_exec_in ##1 idle_enter_out);
  c_sleep: cover property (sleep_exec_in ##1 sleep_enter_out);
  c_apply: cover property (freq_apply_out);
endmodule // occs_assertions

// [tb/occs_partner.sv]
// External oscillators and tick sources seen by the clock control block
`timescale 1ns/10ps
module occs_partner (
  input wire logic mclk_in, // System clock
  input wire logic rst_n_in, // Reset, active low
  input wire logic slow_in, // Wider tick spacing
  output logic osc_pin_out, // External clock level
  output logic prim_run_out, // Primary oscillating
  output logic sec_run_out, // Secondary stable
  output logic rc_ready_out, // Fast RC settled
  output logic [3:0] tick_out // Per-source ticks
);
  logic [5:0] age;
  logic [2:0] phase;
  // Oscillators need time to start, so sources are not stable at once
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      age <= 6'h00;
      phase <= 3'h0;
      osc_pin_out <= 1'b0;
    end
    else
    begin
      age <= (age == 6'h3F) ? age : age + 6'h01;
      phase <= (phase >= (slow_in ? 3'h5 : 3'h1)) ? 3'h0 : phase + 3'h1;
      osc_pin_out <= ~osc_pin_out;
    end
  end
  assign prim_run_out = (age > 6'h28);
  assign sec_run_out = (age > 6'h20);
  assign rc_ready_out = (age > 6'h30);
  assign tick_out = (phase == 3'h0) ? 4'hE : 4'h0;
endmodule // occs_partner

// [tb/occs_top_tb.sv]
// Self-checking bench for the clock control block
`timescale 1ns/10ps
`include "occs_params.svh"
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin failures++; \
  $display("mismatch %s exp %0h got %0h", n, e, a); end end
module occs_top_tb;
  import occs_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic slow = 1'b0;
  logic sleep_x = 1'b0;
  logic two_sp = 1'b0;
  logic ext6 = 1'b0;
  logic ext7 = 1'b0;
  occs_mode_e mode = OCCS_MODE_INT_CLKOUT;
  occs_avm_req_s req = '0;
  occs_pin_s gp6 = '0;
  occs_pin_s gp7 = '0;
  logic [31:0] rdata;
  logic wreq, irq, p6, p6oe, p7, p7oe, run, srun, rdy, opin, pause, div, apply, pll, ide, sle;
  logic [3:0] ticks;
  logic [2:0] freq;
  logic [5:0] trim;
  occs_src_e act;
  int failures = 0;
  int comparisons = 0;
  int seed = 32'had2c9b42;
  logic seen_apply = 1'b0;
  logic [7:0] q;
  logic [7:0] d;
  logic [1:0] srcs [4] = '{2'b01, 2'b10, 2'b11, 2'b00};
  always #20 mclk_in = ~mclk_in;
  always @(posedge mclk_in)
  begin
    gp6 <= occs_pin_s'($random(seed));
    gp7 <= occs_pin_s'($random(seed));
    ext6 <= 1'($random(seed));
    ext7 <= 1'($random(seed));
    if (apply === 1'b1) seen_apply <= 1'b1;
  end
  occs_top DUT (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .ce_in(1'b1), .avm_req_in(req),
    .avm_readdata_out(rdata), .avm_waitrequest_out(wreq), .irq_out(irq),
    .osc_mode_cfg_in(mode), .two_speed_startup_cfg_in(two_sp), .primary_osc_in(opin),
    .primary_running_in(run), .secondary_running_in(srun), .fast_rc_ready_in(rdy),
    .src_tick_in(ticks), .sleep_exec_in(sleep_x), .gpio6_in(gp6), .gpio7_in(gp7),
    .port_a_pin6_in(p6oe ? p6 : ext6), .port_a_pin7_in(p7oe ? p7 : ext7),
    .port_a_pin6_out(p6), .port_a_pin6_oe_out(p6oe), .port_a_pin7_out(p7),
    .port_a_pin7_oe_out(p7oe), .primary_osc_out(), .primary_osc_oe_out(), .gpio_level_out(),
    .active_src_out(act), .clock_pause_out(pause), .fast_rc_freq_sel_out(freq),
    .fast_rc_div256_out(div), .freq_apply_out(apply), .fast_rc_trim_out(trim),
    .pll_on_out(pll), .idle_enter_out(ide), .sleep_enter_out(sle));
  occs_partner u_osc (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .slow_in(slow),
    .osc_pin_out(opin), .prim_run_out(run), .sec_run_out(srun), .rc_ready_out(rdy),
    .tick_out(ticks));
  function automatic occs_src_e exp_src(input logic [1:0] s, input occs_mode_e m);
    return (s == 2'b00) ? (m[2] ? OCCS_SRC_INTERNAL : OCCS_SRC_PRIMARY) : occs_src_e'(s);
  endfunction
  function automatic logic exp_pll(input logic b, input occs_mode_e m);
    return (m == OCCS_MODE_EXT_PLL) | (b & (m == 3'b010 | m == 3'b100 | m == 3'b110));
  endfunction
  task automatic end_sim;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Request held until the edge that sees waitrequest low
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] dv);
    req.read <= ~w;
    req.write <= w;
    req.address <= a;
    req.writedata <= {24'h0, dv};
    req.byteenable <= 4'hF;
    @(posedge mclk_in);
    while (wreq) @(posedge mclk_in);
    q = rdata[7:0];
    `CHK("waitrequest", 1'b0, wreq)
    req.read <= 1'b0;
    req.write <= 1'b0;
    repeat (2) @(posedge mclk_in);
  endtask
  task automatic chk_rd(input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    `CHK("register", e, q)
  endtask
  task automatic do_reset(input occs_mode_e m, input logic ts);
    mode <= m;
    two_sp <= ts;
    rst_n_in <= 1'b0;
    repeat (6) @(posedge mclk_in);
    @(negedge mclk_in) rst_n_in <= 1'b1;
    @(posedge mclk_in);
  endtask
  task automatic wait_sw;
    repeat (3000) if (pause) @(posedge mclk_in);
    @(posedge mclk_in);
    `CHK("pause", 1'b0, pause)
  endtask
  initial
  begin
    do_reset(OCCS_MODE_INT_CLKOUT, 1'b0);
    chk_rd(`OCCS_OFF_CONTROL, 8'h60);
    chk_rd(`OCCS_OFF_TUNING, 8'h00);
    chk_rd(5'h14, 8'h00);
    `CHK("freq_sel", 3'h6, freq)
    wait_sw();
    `CHK("active_src", OCCS_SRC_INTERNAL, act)
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b1, `OCCS_OFF_CONTROL, {1'b0, 3'(i), 4'h0});
      `CHK("freq_sel", 3'(i), freq)
      chk_rd(`OCCS_OFF_CONTROL, {1'b0, 3'(i), 4'h4});
    end
    `CHK("freq_apply", 1'b1, seen_apply)
    bus(1'b1, `OCCS_OFF_CONTROL, 8'h00);
    // Trim extremes first, then random settings
    for (int i = 0; i < 6; i++)
    begin
      d = (i == 0) ? 8'h1F : (i == 1) ? 8'hE0 : 8'($random(seed));
      bus(1'b1, `OCCS_OFF_TUNING, d);
      `CHK("trim", d[5:0], trim)
      `CHK("div256", d[7], div)
      `CHK("pll", exp_pll(d[6], mode), pll)
      chk_rd(`OCCS_OFF_TUNING, d);
    end
    bus(1'b1, `OCCS_OFF_IRQ_MASK, 8'h01);
    bus(1'b1, `OCCS_OFF_IRQ_STAT, 8'h0F);
    foreach (srcs[k])
    begin
      slow <= 1'($random(seed));
      bus(1'b1, `OCCS_OFF_CONTROL, {6'h18, srcs[k]});
      wait_sw();
      `CHK("active_src", exp_src(srcs[k], mode), act)
      `CHK("irq", 1'b1, irq)
      bus(1'b1, `OCCS_OFF_IRQ_STAT, 8'h01);
      `CHK("irq", 1'b0, irq)
    end
    bus(1'b1, `OCCS_OFF_IRQ_MASK, 8'h00);
    bus(1'b1, `OCCS_OFF_CONTROL, 8'h60);
    chk_rd(`OCCS_OFF_CONTROL, 8'h6C);
    for (int i = 0; i < 2; i++)
    begin
      bus(1'b1, `OCCS_OFF_CONTROL, {1'(i), 7'h60});
      sleep_x <= 1'b1;
      @(posedge mclk_in);
      sleep_x <= 1'b0;
      @(posedge mclk_in);
      `CHK("idle_enter", 1'(i), ide)
      `CHK("sleep_enter", ~1'(i), sle)
    end
    bus(1'b0, `OCCS_OFF_IRQ_STAT, 8'h00);
    `CHK("stat_power", 1'b1, q[3])
    `CHK("irq_masked", 1'b0, irq)
    for (int m = 0; m < 8; m++)
    begin
      do_reset(occs_mode_e'(m[2:0]), m[0]);
      chk_rd(`OCCS_OFF_CONTROL, {4'h6, m[0], 3'h0});
      bus(1'b0, `OCCS_OFF_STATE, 8'h00);
      `CHK("mode", m[2:0], q[6:4])
      bus(1'b1, `OCCS_OFF_TUNING, 8'h40);
      `CHK("pll", exp_pll(1'b1, occs_mode_e'(m[2:0])), pll)
      repeat (20) @(posedge mclk_in);
    end
    end_sim();
  end
  initial
  begin
    #3200000;
    failures++;
    end_sim();
  end
endmodule // occs_top_tb
bind occs_top occs_assertions u_chk (.*);
